/* File: core/eds_sync_serial.sv */
`timescale 1ns/1ps
`include "eds_regs.svh"
// Summary of operation
// - Every second server cycle of a receive shifts the receive pin into the high byte.
// - Eight bits are received in sixteen server cycles, then one end interrupt.
// - Cycle counter holds twice the bit count; that many server cycles per word.
// - At counter zero the next channel event goes to the conventional interrupt.
// - Sync value zero samples receive data on even server cycles.
// - Sync value 02H drives transmit data on the first cycle of each pair.
// - Mode value 72H puts the server in synchronous serial mode.
// - External shift clock takes timing only from arriving edges, not the timer.
// - Compare mode generates the shift clock from base timer and bit period.
// - Channel value 30H captures both clock edges, one event each.
// - Channel value 70H compares, raising an event and toggling the pin.
// - Input clock only via capture/compare channel; output via either kind.
// - Each transfer control block starts at an address divisible by 8.
// - External clock starts at first pulse; internal starts on compare write.
// - Shifting continues until end interrupt or server disabled.
// - Last transmit cycle still schedules next toggle; channel must be stopped.
module eds_sync_serial import eds_pkg::*; #(
   parameter int TIME_W = `EDS_TIME_W
) (
   input  wire logic              mclk,
   input  wire logic              rst_b,
   input  wire eds_cfg_type       cfg,
   input  wire logic [7:0]        channel_control,
   input  wire logic              compare_only_channel,
   input  wire logic              server_select_set,
   input  wire logic              compare_time_wr,
   input  wire logic [TIME_W-1:0] compare_time_in,
   input  wire logic              data_clear,
   input  wire logic [7:0]        tx_data_in,
   input  wire logic              tx_data_load,
   input  wire logic              shift_clock_in,
   input  wire logic              receive_pin,
   input  wire logic              clock_pin_init,
   output logic                   shift_clock_out,
   output logic                   shift_clock_oe,
   output logic                   transmit_pin,
   output logic [15:0]            shift_data_word,
   output logic                   server_select_bits,
   output logic                   end_interrupt,
   output logic                   server_busy,
   output logic                   config_error,
   output logic [TIME_W-1:0]      base_timer
);
   eds_state_type state_r, state_nxt;
   logic [2:0]        sck_sync_r, sck_sync_nxt;
   logic              sck_prev_r, sck_prev_nxt;
   logic [2:0]        rxd_sync_r, rxd_sync_nxt;
   logic              rxd_level_r, rxd_level_nxt;
   logic              serve_evt;
   logic [TIME_W-1:0] timer_r, timer_nxt;
   logic [TIME_W-1:0] cmp_time_r, cmp_time_nxt;
   logic              cmp_armed_r, cmp_armed_nxt;
   logic              sck_out_r, sck_out_nxt;
   logic              txd_r, txd_nxt;
   logic [15:0]       data_r, data_nxt;
   logic [7:0]        count_r, count_nxt;
   logic              odd_r, odd_nxt;
   logic              sel_r, sel_nxt;
   logic              irq_r, irq_nxt;
   logic              ext_edge, cmp_match, chan_event, sync_serial_mode_mode, cap_mode, cmp_mode;
   logic              cfg_ok;

   assign sync_serial_mode_mode = (cfg.server_mode_control == `EDS_MODE_SYNC_SERIAL_MODE);
   assign cap_mode  = (channel_control == `EDS_CHAN_CAP_BOTH);
   assign cmp_mode  = (channel_control == `EDS_CHAN_CMP_TOG);
   // Input clock not allowed on a compare-only channel
   assign cfg_ok    = !(cap_mode && compare_only_channel) &&
                      (cfg.transfer_control_block[2:0] == `EDS_CBLK_ALIGN);

   // Pin samplers; a level counts once the last two stages agree
   always_comb begin
      sck_sync_nxt  = {sck_sync_r[1:0], shift_clock_in};
      sck_prev_nxt  = sck_prev_r;
      rxd_sync_nxt  = {rxd_sync_r[1:0], receive_pin};
      rxd_level_nxt = rxd_level_r;
      if (sck_sync_r[2] == sck_sync_r[1]) begin
         sck_prev_nxt = sck_sync_r[2];
      end
      if (rxd_sync_r[2] == rxd_sync_r[1]) begin
         rxd_level_nxt = rxd_sync_r[2];
      end
   end

   always_ff @(posedge mclk or negedge rst_b) begin
      if (!rst_b) begin
         sck_sync_r  <= 3'h0;
         sck_prev_r  <= 1'b0;
         rxd_sync_r  <= 3'h0;
         rxd_level_r <= 1'b0;
      end else begin
         sck_sync_r  <= sck_sync_nxt;
         sck_prev_r  <= sck_prev_nxt;
         rxd_sync_r  <= rxd_sync_nxt;
         rxd_level_r <= rxd_level_nxt;
      end
   end

   // Both edges give one event each, timer unused
   assign ext_edge  = cap_mode && (sck_sync_r[2] == sck_sync_r[1]) &&
                      (sck_sync_r[2] != sck_prev_r);
   assign cmp_match = cmp_mode && cmp_armed_r && (timer_r == cmp_time_r);
   assign chan_event = cfg_ok && (ext_edge || cmp_match);

   // Event that the server actually takes
   assign serve_evt  = (state_r == EDS_RUN) && sel_r && chan_event && sync_serial_mode_mode;

   always_comb begin
      timer_nxt    = timer_r + TIME_W'(1);
      cmp_time_nxt = cmp_time_r;
      cmp_armed_nxt = cmp_armed_r;
      sck_out_nxt  = sck_out_r;
      txd_nxt      = txd_r;
      data_nxt     = data_r;
      count_nxt    = count_r;
      odd_nxt      = odd_r;
      sel_nxt      = sel_r;
      irq_nxt      = 1'b0;
      state_nxt    = state_r;
      // Idle level only while no compare drives the pin
      if (state_r == EDS_IDLE && !cmp_mode) begin
         sck_out_nxt = clock_pin_init;
      end
      if (!cmp_mode) begin
         cmp_armed_nxt = 1'b0;
      end
      if (compare_time_wr) begin
         cmp_time_nxt  = compare_time_in;
         cmp_armed_nxt = 1'b1;
      end
      if (cmp_match) begin
         sck_out_nxt  = ~sck_out_r;
         // Next toggle always scheduled, even after the last cycle
         cmp_time_nxt = cmp_time_r + cfg.bit_period_constant[TIME_W-1:0];
      end
      if (data_clear) begin
         data_nxt = 16'h0000;
      end
      if (tx_data_load) begin
         data_nxt[7:0] = tx_data_in;
      end
      case (state_r)
         EDS_IDLE: begin
         end
         EDS_RUN: begin
            if (!sel_r) begin
               state_nxt = EDS_IDLE;
            end else if (chan_event && sync_serial_mode_mode) begin
               if (count_r == `EDS_CNT_ZERO) begin
                  irq_nxt   = 1'b1;
                  sel_nxt   = 1'b0;
                  state_nxt = EDS_DONE;
               end else begin
                  count_nxt = count_r - `EDS_CNT_STEP;
                  odd_nxt   = ~odd_r;
                  if (cfg.sync_phase_control == `EDS_SYNC_ODD && !odd_r) begin
                     txd_nxt  = data_r[0];
                     data_nxt = {1'b0, data_r[15:1]};
                  end
                  if (cfg.sync_phase_control == `EDS_SYNC_EVEN && odd_r) begin
                     data_nxt = {rxd_level_r, data_r[15:9], data_r[7:0]};
                  end
               end
            end
         end
         EDS_DONE: begin
            if (!server_select_set) begin
               state_nxt = EDS_IDLE;
            end
         end
         default: state_nxt = EDS_IDLE;
      endcase
      // Software restart wins over a word ending in the same cycle
      if (server_select_set) begin
         sel_nxt   = 1'b1;
         count_nxt = cfg.server_cycle_counter;
         odd_nxt   = 1'b0;
         state_nxt = EDS_RUN;
      end
   end

   always_ff @(posedge mclk or negedge rst_b) begin
      if (!rst_b) begin
         state_r     <= EDS_IDLE;
         timer_r     <= '0;
         cmp_time_r  <= '0;
         cmp_armed_r <= 1'b0;
         sck_out_r   <= 1'b1;
         txd_r       <= 1'b1;
         data_r      <= 16'h0000;
         count_r     <= 8'h00;
         odd_r       <= 1'b0;
         sel_r       <= 1'b0;
         irq_r       <= 1'b0;
      end else begin
         state_r     <= state_nxt;
         timer_r     <= timer_nxt;
         cmp_time_r  <= cmp_time_nxt;
         cmp_armed_r <= cmp_armed_nxt;
         sck_out_r   <= sck_out_nxt;
         txd_r       <= txd_nxt;
         data_r      <= data_nxt;
         count_r     <= count_nxt;
         odd_r       <= odd_nxt;
         sel_r       <= sel_nxt;
         irq_r       <= irq_nxt;
      end
   end

   assign shift_clock_out    = sck_out_r;
   assign shift_clock_oe     = cmp_mode;
   assign transmit_pin       = txd_r;
   assign shift_data_word    = data_r;
   assign server_select_bits = sel_r;
   assign end_interrupt      = irq_r;
   assign server_busy        = (state_r == EDS_RUN);
   assign config_error       = !cfg_ok;
   assign base_timer         = timer_r;

   a_end_irq_clears: assert property (@(posedge mclk) disable iff (!rst_b)
      end_interrupt |-> !server_select_bits) else $error("select bit not cleared");
   a_zero_count_irq: assert property (@(posedge mclk) disable iff (!rst_b)
      (state_r == EDS_RUN && sel_r && chan_event && sync_serial_mode_mode && count_r == `EDS_CNT_ZERO
       && !server_select_set) |=> end_interrupt) else $error("missing end interrupt");
   a_count_steps: assert property (@(posedge mclk) disable iff (!rst_b)
      (state_r == EDS_RUN && sel_r && chan_event && sync_serial_mode_mode && count_r != `EDS_CNT_ZERO
       && !server_select_set) |=> (count_r == $past(count_r) - `EDS_CNT_STEP))
      else $error("counter not decremented");
   a_irq_single: assert property (@(posedge mclk) disable iff (!rst_b)
      end_interrupt |=> !end_interrupt) else $error("double end interrupt");
   a_cmp_toggle: assert property (@(posedge mclk) disable iff (!rst_b)
      (cmp_match && state_r != EDS_IDLE) |=> (shift_clock_out != $past(shift_clock_out)))
      else $error("no toggle on match");
   a_ext_no_timer: assert property (@(posedge mclk) disable iff (!rst_b)
      cap_mode |-> !cmp_match) else $error("timer used with external clock");
   a_rx_shift: assert property (@(posedge mclk) disable iff (!rst_b)
      (serve_evt && count_r != `EDS_CNT_ZERO && odd_r
       && cfg.sync_phase_control == `EDS_SYNC_EVEN && !data_clear)
      |=> (shift_data_word[15] == $past(rxd_level_r))) else $error("rx bit not shifted");
   a_tx_drive: assert property (@(posedge mclk) disable iff (!rst_b)
      (serve_evt && count_r != `EDS_CNT_ZERO && !odd_r
       && cfg.sync_phase_control == `EDS_SYNC_ODD)
      |=> (transmit_pin == $past(data_r[0]))) else $error("tx bit not driven");
   a_align_check: assert property (@(posedge mclk) disable iff (!rst_b)
      (cfg.transfer_control_block[2:0] != `EDS_CBLK_ALIGN) |-> !chan_event)
      else $error("misaligned block served");

   // Pair phases: the other cycle of each pair leaves data alone; the transmit cycle shifts the word
   a_rx_first_idle: assert property (@(posedge mclk) disable iff (!rst_b)
      (serve_evt && count_r != `EDS_CNT_ZERO && !odd_r && !data_clear && !tx_data_load
       && cfg.sync_phase_control == `EDS_SYNC_EVEN)
      |=> (shift_data_word == $past(shift_data_word))) else $error("rx sampled early");
   a_tx_second_hold: assert property (@(posedge mclk) disable iff (!rst_b)
      (serve_evt && count_r != `EDS_CNT_ZERO && odd_r
       && cfg.sync_phase_control == `EDS_SYNC_ODD)
      |=> (transmit_pin == $past(transmit_pin))) else $error("tx changed on second cycle");
   a_tx_shift_out: assert property (@(posedge mclk) disable iff (!rst_b)
      (serve_evt && count_r != `EDS_CNT_ZERO && !odd_r && !data_clear && !tx_data_load
       && cfg.sync_phase_control == `EDS_SYNC_ODD)
      |=> (shift_data_word == {1'b0, $past(shift_data_word[15:1])}))
      else $error("tx word not shifted");

   // Run control
   a_set_loads: assert property (@(posedge mclk) disable iff (!rst_b)
      server_select_set
      |=> (server_select_bits && count_r == $past(cfg.server_cycle_counter)))
      else $error("counter not loaded");
   a_busy_holds: assert property (@(posedge mclk) disable iff (!rst_b)
      (state_r == EDS_RUN && sel_r && !(serve_evt && count_r == `EDS_CNT_ZERO))
      |=> server_busy)
      else $error("server stopped early");
   a_refuse_mode: assert property (@(posedge mclk) disable iff (!rst_b)
      (state_r == EDS_RUN && sel_r && !sync_serial_mode_mode && !server_select_set)
      |=> (count_r == $past(count_r)))
      else $error("event served outside serial mode");
   a_irq_idle: assert property (@(posedge mclk) disable iff (!rst_b)
      (end_interrupt && !$past(server_select_set)) |-> !server_busy)
      else $error("busy after end interrupt");
   a_done_idle: assert property (@(posedge mclk) disable iff (!rst_b)
      (state_r == EDS_DONE && !server_select_set) |=> (state_r == EDS_IDLE))
      else $error("done state not left");

   // Timing source and channel kinds
   a_timer_runs: assert property (@(posedge mclk) disable iff (!rst_b)
      $past(rst_b) |-> (base_timer == $past(base_timer) + TIME_W'(1)))
      else $error("base timer stalled");
   a_capture_refused: assert property (@(posedge mclk) disable iff (!rst_b)
      (cap_mode && compare_only_channel) |-> config_error)
      else $error("capture on compare-only channel");
   a_ext_no_drive: assert property (@(posedge mclk) disable iff (!rst_b)
      cap_mode |-> !shift_clock_oe)
      else $error("clock driven in capture mode");

   c_end_irq: cover property (@(posedge mclk) disable iff (!rst_b) end_interrupt);
   c_ext_edge: cover property (@(posedge mclk) disable iff (!rst_b) ext_edge && server_busy);
   c_cmp_match: cover property (@(posedge mclk) disable iff (!rst_b) cmp_match && server_busy);
   c_rx_word: cover property (@(posedge mclk) disable iff (!rst_b) end_interrupt && cap_mode);
   c_tx_word: cover property (@(posedge mclk) disable iff (!rst_b) end_interrupt && cmp_mode);
endmodule

/* File: core/eds_regs.svh */
`ifndef EDS_REGS_SVH
`define EDS_REGS_SVH
`define EDS_MODE_SYNC_SERIAL_MODE      8'h72
`define EDS_CHAN_OFF       8'h00
`define EDS_CHAN_CAP_BOTH  8'h30
`define EDS_CHAN_CMP_TOG   8'h70
`define EDS_SYNC_EVEN      8'h00
`define EDS_SYNC_ODD       8'h02
`define EDS_CBLK_ALIGN     3'h0
`define EDS_CNT_ZERO       8'h00
`define EDS_CNT_STEP       8'h01
`define EDS_BYTE_W         8
`define EDS_TIME_W         16
`endif

/* File: core/eds_pkg.sv */
package eds_pkg;
   typedef enum logic [2:0] {
      EDS_IDLE = 3'b001,
      EDS_RUN  = 3'b010,
      EDS_DONE = 3'b100
   } eds_state_type;
   typedef struct packed {
      logic [7:0]  server_mode_control;
      logic [7:0]  sync_phase_control;
      logic [7:0]  server_cycle_counter;
      logic [15:0] bit_period_constant;
      logic [15:0] transfer_control_block;
   } eds_cfg_type;
endpackage

/* File: verification/eds_partner.sv */
`timescale 1ns/1ps
module eds_partner (
   input  wire logic shift_clock_out,
   input  wire logic transmit_pin,
   output logic      shift_clock_in,
   output logic      receive_pin,
   output logic [7:0] rx_byte,
   output int        toggles,
   output time       gap_ns
);
   time last_t;
   initial begin
      shift_clock_in = 1'b0;
      receive_pin = 1'b0;
      rx_byte = 8'h00;
      toggles = 0;
      gap_ns = 0;
      last_t = 0;
   end
   // Captures data on each rising shift clock
   always @(shift_clock_out) begin
      toggles = toggles + 1;
      gap_ns = $time - last_t;
      last_t = $time;
      if (shift_clock_out === 1'b1) rx_byte = {transmit_pin, rx_byte[7:1]};
   end
   // Clock moves only inside a frame, LSB first
   task automatic send_byte(input logic [7:0] b, input int edges);
      for (int i = 0; i < edges; i++) begin
         #24;
         if (i % 2 == 0) receive_pin = b[(i / 2) % 8];
         #8 shift_clock_in = ~shift_clock_in;
      end
      #24 receive_pin = ~receive_pin;
   endtask
endmodule

/* File: verification/tb_top.sv */
`timescale 1ns/1ps
module tb_top import eds_pkg::*; ;
   logic mclk, rst_b, compare_only_channel, server_select_set, compare_time_wr;
   logic data_clear, tx_data_load, shift_clock_in, receive_pin, clock_pin_init;
   logic shift_clock_out, shift_clock_oe, transmit_pin, server_select_bits;
   logic end_interrupt, server_busy, config_error;
   logic [7:0] channel_control, tx_data_in, rx_byte, tx_snap;
   logic [15:0] compare_time_in, shift_data_word, base_timer;
   eds_cfg_type cfg;
   int err_count, samples_checked, irq_count, cycles, toggles, tg;
   time gap_ns;
   eds_sync_serial eds_sync_serial_inst (.mclk(mclk), .rst_b(rst_b), .cfg(cfg),
      .channel_control(channel_control), .compare_only_channel(compare_only_channel),
      .server_select_set(server_select_set), .compare_time_wr(compare_time_wr),
      .compare_time_in(compare_time_in), .data_clear(data_clear),
      .tx_data_in(tx_data_in), .tx_data_load(tx_data_load),
      .shift_clock_in(shift_clock_in), .receive_pin(receive_pin),
      .clock_pin_init(clock_pin_init), .shift_clock_out(shift_clock_out),
      .shift_clock_oe(shift_clock_oe), .transmit_pin(transmit_pin),
      .shift_data_word(shift_data_word), .server_select_bits(server_select_bits),
      .end_interrupt(end_interrupt), .server_busy(server_busy),
      .config_error(config_error), .base_timer(base_timer));
   eds_partner eds_partner_inst (.shift_clock_out(shift_clock_out),
      .transmit_pin(transmit_pin), .shift_clock_in(shift_clock_in),
      .receive_pin(receive_pin), .rx_byte(rx_byte), .toggles(toggles), .gap_ns(gap_ns));
   initial begin
      mclk = 1'b0;
      forever #2 mclk = ~mclk;
   end
   task automatic print_verdict();
      if (err_count == 0 && samples_checked > 0) $display("Testbench passed");
      else $display("Testbench failed");
      $finish;
   endtask
   task automatic check(input logic [15:0] got, input logic [15:0] exp);
      samples_checked++;
      if (got !== exp) begin
         err_count++;
         $display("mismatch at %0t: got %h expected %h", $time, got, exp);
      end
   endtask
   task automatic strobe(input int k);
      @(negedge mclk);
      case (k)
         0: server_select_set = 1'b1;
         1: data_clear = 1'b1;
         2: tx_data_load = 1'b1;
         default: compare_time_wr = 1'b1;
      endcase
      @(negedge mclk);
      {server_select_set, data_clear, tx_data_load, compare_time_wr} = 4'h0;
   endtask
   task automatic rx_word(input logic [7:0] mode, input logic [7:0] b);
      cfg.server_mode_control = mode;
      strobe(1);
      strobe(0);
      channel_control = 8'h30;
      eds_partner_inst.send_byte(b, 17);
      repeat (8) @(negedge mclk);
   endtask
   always @(posedge mclk) begin
      cycles++;
      if (end_interrupt === 1'b1) irq_count++;
      if (end_interrupt === 1'b1) tx_snap <= rx_byte;
      if (cycles == 6000) begin
         err_count++;
         print_verdict();
      end
   end
   initial begin
      cfg = '{8'h72, 8'h00, 8'h10, 16'h0003, 16'h0110};
      {rst_b, compare_only_channel, server_select_set, compare_time_wr} = 4'h0;
      {data_clear, tx_data_load, clock_pin_init} = 3'h1;
      channel_control = 8'h00;
      tx_data_in = 8'h00;
      compare_time_in = 16'h0000;
      repeat (10) @(negedge mclk);
      check(16'({shift_clock_out, transmit_pin, server_select_bits, end_interrupt}), 16'h000c);
      check(shift_data_word | base_timer, 16'h0000);
      rst_b = 1'b1;
      rx_word(8'h72, 8'ha5);
      check(16'(shift_data_word[15:8]), 16'h00a5);
      check(16'(irq_count), 16'h0001);
      check(16'({server_select_bits, server_busy}), 16'h0000);
      channel_control = 8'h00;
      rx_word(8'h00, 8'h3c);
      check(shift_data_word | 16'(irq_count), 16'h0001);
      channel_control = 8'h00;
      cfg.transfer_control_block = 16'h0114;
      @(negedge mclk) check(16'(config_error), 16'h0001);
      cfg = '{8'h72, 8'h02, 8'h10, 16'h0020, 16'h0110};
      {compare_only_channel, channel_control} = {1'b1, 8'h30};
      @(negedge mclk) check(16'(config_error), 16'h0001);
      channel_control = 8'h70;
      @(negedge mclk) check(16'({config_error, shift_clock_oe}), 16'h0001);
      compare_only_channel = 1'b0;
      tx_data_in = 8'h96;
      strobe(2);
      strobe(0);
      tg = toggles;
      repeat (100) @(negedge mclk);
      check(16'(toggles - tg), 16'h0000);
      compare_time_in = base_timer + 16'h0080;
      strobe(3);
      repeat (300) @(negedge mclk);
      check(16'(server_busy), 16'h0001);
      for (int i = 0; i < 2000 && irq_count < 2; i++) @(negedge mclk);
      check(16'(tx_snap), 16'h0096);
      tg = toggles;
      repeat (80) @(negedge mclk);
      check(16'(toggles > tg), 16'h0001);
      check(16'(gap_ns), 16'd128);
      channel_control = 8'h00;
      repeat (2) @(negedge mclk);
      tg = toggles;
      repeat (100) @(negedge mclk);
      check(16'(toggles - tg), 16'h0000);
      print_verdict();
   end
endmodule
